// [hdl/ictl_pkg.sv]
package ictl_pkg;

  // --------------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_PEN_A   = 8'h04;
  localparam logic [7:0] A_PEN_B   = 8'h08;
  localparam logic [7:0] A_PFL_A   = 8'h0C;
  localparam logic [7:0] A_PFL_B   = 8'h10;
  localparam logic [7:0] A_OPT     = 8'h14;
  localparam logic [7:0] A_SH_W    = 8'h18;
  localparam logic [7:0] A_SH_ST   = 8'h1C;
  localparam logic [7:0] A_SH_BSR  = 8'h20;
  localparam logic [7:0] A_SH_PTR  = 8'h24;
  localparam logic [7:0] A_SH_PCH  = 8'h28;
  localparam logic [7:0] A_CORE    = 8'h2C;

  // --------------------------------------------------------------------------
  // control register fields and other constants
  // --------------------------------------------------------------------------
  localparam int B_GIE  = 7;
  localparam int B_PERIPH_GROUP_ENABLE = 6;
  localparam int B_T0E  = 5;
  localparam int B_EXE  = 4;
  localparam int B_PCE  = 3;
  localparam int B_T0F  = 2;
  localparam int B_EXF  = 1;
  localparam int B_PCF  = 0;
  localparam int B_OSF  = 7;
  localparam int B_EDGE = 0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] ST_KEEP_MSK = 8'hE7;
  localparam logic [15:0] VECTOR    = 16'h0004;
  localparam logic [2:0] Q1 = 3'h0;
  localparam logic [2:0] Q4 = 3'h3;
  localparam int RSP_OKAY = 0;

  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [4:0]  bank_select_reg;
    logic [31:0] ptrs;
    logic [6:0]  pch;
  } ictl_ctx_s;

  typedef enum logic [1:0] {S_RUN, S_ENTRY, S_SLEEP, S_WAKE} ictl_state_e;

endpackage

// [hdl/ictl_top.sv]
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ictl_top (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [7:0]        haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // event sources
  input  wire logic              ext_pin_i,
  input  wire logic              timer0_ovf_i,
  input  wire logic              pin_change_any_i,
  input  wire logic [7:0]        periph_evt_a_i,
  input  wire logic [7:0]        periph_evt_b_i,
  input  wire logic [7:0]        wake_capable_a_i,
  input  wire logic [7:0]        wake_capable_b_i,
  // core interface
  input  wire logic              q_clk_en_i,
  input  wire logic              instr_done_i,
  input  wire logic              sleep_instr_i,
  input  wire logic              return_from_irq_instr_i,
  input  wire ictl_pkg::ictl_ctx_s core_ctx_i,
  output logic                   flush_o,
  output logic                   push_pc_o,
  output logic                   pop_pc_o,
  output logic                   load_vector_o,
  output logic [15:0]            vector_o,
  output logic                   restore_o,
  output ictl_pkg::ictl_ctx_s    restore_ctx_o,
  output logic                   sleeping_o,
  output logic                   wake_o
);

  // --------------------------------------------------------------------------
  // quadrature phase and pin synchroniser
  // --------------------------------------------------------------------------
  logic [1:0] q_ff;
  logic [2:0] pin_sync_ff;
  logic       pin_lvl_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q_ff <= 2'h0;
    end else if (q_clk_en_i) begin
      q_ff <= q_ff + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_sync_ff <= 3'h0;
      pin_lvl_ff  <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], ext_pin_i};
      if (pin_sync_ff[1] == pin_sync_ff[2]) begin
        pin_lvl_ff <= pin_sync_ff[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0]          ctrl_ff;
  logic [7:0]          pen_a_ff;
  logic [7:0]          pen_b_ff;
  logic [7:0]          pfl_a_ff;
  logic [7:0]          pfl_b_ff;
  logic                edge_sel_ff;
  ictl_pkg::ictl_ctx_s shadow_ff;
  ictl_pkg::ictl_state_e state_ff;

  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic       wr_go;
  logic [7:0] wd;
  assign wr_go = wr_pend_ff;
  assign wd    = hwdata_i[7:0];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (hready_i) begin
      wr_pend_ff <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr_ff <= haddr_i;
    end
  end

  function automatic logic hit(input logic [7:0] a);
    return wr_go && (wr_addr_ff == a);
  endfunction

  // external pin edge, seen in any phase, held and posted to the flag only in Q4-Q1
  logic pin_q_ff;
  logic ext_edge;
  logic q_window;
  assign q_window = (q_ff == ictl_pkg::Q4[1:0]) || (q_ff == ictl_pkg::Q1[1:0]);
  assign ext_edge = edge_sel_ff ? (pin_lvl_ff && !pin_q_ff)
                                : (!pin_lvl_ff && pin_q_ff);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_q_ff <= 1'b0;
    end else begin
      pin_q_ff <= pin_lvl_ff;
    end
  end
  logic ext_hold_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ext_hold_ff <= 1'b0;
    end else if (q_window) begin
      ext_hold_ff <= 1'b0;
    end else if (ext_edge) begin
      ext_hold_ff <= 1'b1;
    end
  end
  logic ext_set;
  assign ext_set = q_window && (ext_edge || ext_hold_ff);

  logic take;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= ictl_pkg::CTRL_RST;
    end else begin
      if (hit(ictl_pkg::A_CTRL)) begin
        ctrl_ff[7:1] <= wd[7:1];
      end
      if (take) begin
        ctrl_ff[ictl_pkg::B_GIE] <= 1'b0;
      end else if (return_from_irq_instr_i) begin
        ctrl_ff[ictl_pkg::B_GIE] <= 1'b1;
      end
      if (timer0_ovf_i) begin
        ctrl_ff[ictl_pkg::B_T0F] <= 1'b1;
      end
      if (ext_set) begin
        ctrl_ff[ictl_pkg::B_EXF] <= 1'b1;
      end
      ctrl_ff[ictl_pkg::B_PCF] <= pin_change_any_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pen_a_ff    <= ictl_pkg::CTRL_RST;
      pen_b_ff    <= ictl_pkg::CTRL_RST;
      edge_sel_ff <= 1'b0;
    end else begin
      if (hit(ictl_pkg::A_PEN_A)) pen_a_ff <= wd;
      if (hit(ictl_pkg::A_PEN_B)) pen_b_ff <= wd;
      if (hit(ictl_pkg::A_OPT))   edge_sel_ff <= wd[ictl_pkg::B_EDGE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pfl_a_ff <= ictl_pkg::CTRL_RST;
      pfl_b_ff <= ictl_pkg::CTRL_RST;
    end else begin
      pfl_a_ff <= (hit(ictl_pkg::A_PFL_A) ? wd : pfl_a_ff) | periph_evt_a_i;
      pfl_b_ff <= (hit(ictl_pkg::A_PFL_B) ? wd : pfl_b_ff) | periph_evt_b_i;
    end
  end

  // --------------------------------------------------------------------------
  // request combine
  // --------------------------------------------------------------------------
  logic periph_req;
  logic core_req;
  logic any_req;
  logic wake_req;
  assign periph_req = ctrl_ff[ictl_pkg::B_PERIPH_GROUP_ENABLE]
                      && |((pfl_a_ff & pen_a_ff) | (pfl_b_ff & pen_b_ff));
  assign core_req = (ctrl_ff[ictl_pkg::B_T0E] && ctrl_ff[ictl_pkg::B_T0F])
                  || (ctrl_ff[ictl_pkg::B_EXE] && ctrl_ff[ictl_pkg::B_EXF])
                  || (ctrl_ff[ictl_pkg::B_PCE] && ctrl_ff[ictl_pkg::B_PCF]);
  assign any_req = core_req || periph_req;
  assign wake_req = (ctrl_ff[ictl_pkg::B_EXE] && ctrl_ff[ictl_pkg::B_EXF])
                  || (ctrl_ff[ictl_pkg::B_PCE] && ctrl_ff[ictl_pkg::B_PCF])
                  || (ctrl_ff[ictl_pkg::B_PERIPH_GROUP_ENABLE]
                      && |((pfl_a_ff & pen_a_ff & wake_capable_a_i)
                         | (pfl_b_ff & pen_b_ff & wake_capable_b_i)));

  // --------------------------------------------------------------------------
  // entry sequencer
  // --------------------------------------------------------------------------
  // decision only at Q1 on an instruction boundary, so a
  // longer running instruction moves the point later
  logic q1_now;
  assign q1_now = q_clk_en_i && (q_ff == ictl_pkg::Q1[1:0]) && instr_done_i;
  assign take = (state_ff == ictl_pkg::S_RUN) && q1_now
                && ctrl_ff[ictl_pkg::B_GIE] && any_req && !return_from_irq_instr_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= ictl_pkg::S_RUN;
    end else begin
      unique case (state_ff)
        ictl_pkg::S_RUN: begin
          if (sleep_instr_i) state_ff <= ictl_pkg::S_SLEEP;
        end
        ictl_pkg::S_ENTRY: state_ff <= ictl_pkg::S_RUN;
        ictl_pkg::S_SLEEP: begin
          if (wake_req) state_ff <= ictl_pkg::S_WAKE;
        end
        ictl_pkg::S_WAKE: begin
          if (instr_done_i) state_ff <= ictl_pkg::S_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flush_o       <= 1'b0;
      push_pc_o     <= 1'b0;
      load_vector_o <= 1'b0;
      pop_pc_o      <= 1'b0;
      restore_o     <= 1'b0;
    end else begin
      flush_o       <= take;
      push_pc_o     <= take;
      load_vector_o <= take;
      pop_pc_o      <= return_from_irq_instr_i;
      restore_o     <= return_from_irq_instr_i;
    end
  end
  assign vector_o   = ictl_pkg::VECTOR;
  assign sleeping_o = (state_ff == ictl_pkg::S_SLEEP);
  assign wake_o     = (state_ff == ictl_pkg::S_WAKE);

  // --------------------------------------------------------------------------
  // shadow context
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      shadow_ff <= '0;
    end else if (take) begin
      shadow_ff        <= core_ctx_i;
      shadow_ff.status <= core_ctx_i.status & ictl_pkg::ST_KEEP_MSK;
    end else begin
      if (hit(ictl_pkg::A_SH_W))   shadow_ff.w      <= wd;
      if (hit(ictl_pkg::A_SH_ST))  shadow_ff.status <= wd & ictl_pkg::ST_KEEP_MSK;
      if (hit(ictl_pkg::A_SH_BSR)) shadow_ff.bank_select_reg    <= wd[4:0];
      if (hit(ictl_pkg::A_SH_PTR)) shadow_ff.ptrs   <= hwdata_i;
      if (hit(ictl_pkg::A_SH_PCH)) shadow_ff.pch    <= wd[6:0];
    end
  end
  assign restore_ctx_o = shadow_ff;

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      unique case (haddr_i)
        ictl_pkg::A_CTRL:   hrdata_o <= {24'h0, ctrl_ff};
        ictl_pkg::A_PEN_A:  hrdata_o <= {24'h0, pen_a_ff};
        ictl_pkg::A_PEN_B:  hrdata_o <= {24'h0, pen_b_ff};
        ictl_pkg::A_PFL_A:  hrdata_o <= {24'h0, pfl_a_ff};
        ictl_pkg::A_PFL_B:  hrdata_o <= {24'h0, pfl_b_ff};
        ictl_pkg::A_OPT:    hrdata_o <= {31'h0, edge_sel_ff};
        ictl_pkg::A_SH_W:   hrdata_o <= {24'h0, shadow_ff.w};
        ictl_pkg::A_SH_ST:  hrdata_o <= {24'h0, shadow_ff.status};
        ictl_pkg::A_SH_BSR: hrdata_o <= {27'h0, shadow_ff.bank_select_reg};
        ictl_pkg::A_SH_PTR: hrdata_o <= shadow_ff.ptrs;
        ictl_pkg::A_SH_PCH: hrdata_o <= {25'h0, shadow_ff.pch};
        ictl_pkg::A_CORE:   hrdata_o <= {28'h0, pin_lvl_ff, 1'b0, state_ff};
        default:            hrdata_o <= 32'h0000_0000;
      endcase
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule

`default_nettype wire

// [dv/ictl_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ictl_core_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // pacing and stack
  input  wire logic        slow_i,
  input  wire logic        push_pc_i,
  input  wire logic        pop_pc_i,
  // to controller, depth to testbench
  output logic             q_clk_en_o,
  output logic             instr_done_o,
  output logic [3:0]       depth_o
);
  logic [1:0] ph_ff;
  logic       odd_ff;
  logic [3:0] depth_ff;
  // slow pacing: one phase every other clock
  assign q_clk_en_o   = !slow_i || odd_ff;
  assign instr_done_o = ph_ff == 2'h0;
  assign depth_o      = depth_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ph_ff    <= 2'h0;
      odd_ff   <= 1'b0;
      depth_ff <= 4'h0;
    end else begin
      odd_ff <= !odd_ff;
      if (q_clk_en_o) begin
        ph_ff <= ph_ff + 2'h1;
      end
      depth_ff <= depth_ff + {3'h0, push_pc_i} - {3'h0, pop_pc_i};
    end
  end
endmodule
`default_nettype wire

// [dv/ictl_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ictl_top_sva (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        return_from_irq_instr_i,
  input wire logic        q_clk_en_i,
  input wire logic        instr_done_i,
  input wire logic        sleep_instr_i,
  input wire logic        flush_o,
  input wire logic        push_pc_o,
  input wire logic        pop_pc_o,
  input wire logic        load_vector_o,
  input wire logic [15:0] vector_o,
  input wire logic        restore_o,
  input wire logic        sleeping_o,
  input wire logic        wake_o,
  input wire logic        hresp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  rst_quiet_a: assert property ($rose(rst_b_i) |-> !flush_o && !pop_pc_o && !sleeping_o)
    else $error("activity right after reset");
  vec_fix_a: assert property (load_vector_o |-> vector_o == 16'h0004)
    else $error("wrong vector");
  entry_set_a: assert property (flush_o |-> push_pc_o && load_vector_o)
    else $error("entry pulses apart");
  entry_cause_a: assert property (flush_o |-> $past(q_clk_en_i && instr_done_i && !return_from_irq_instr_i))
    else $error("entry off boundary");
  entry_once_a: assert property (flush_o |=> !flush_o [*3])
    else $error("entry repeated");
  ret_act_a: assert property (return_from_irq_instr_i |=> pop_pc_o && restore_o && !flush_o)
    else $error("return not acted");
  pop_cause_a: assert property (pop_pc_o |-> $past(return_from_irq_instr_i))
    else $error("pop without return");
  sleep_go_a: assert property (sleep_instr_i |=> sleeping_o)
    else $error("sleep not entered");
  wake_hold_a: assert property (wake_o && !instr_done_i |=> wake_o)
    else $error("wake dropped early");
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
endmodule
bind ictl_top ictl_top_sva i_ictl_top_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .return_from_irq_instr_i(return_from_irq_instr_i), .q_clk_en_i(q_clk_en_i), .instr_done_i(instr_done_i),
  .sleep_instr_i(sleep_instr_i), .flush_o(flush_o), .push_pc_o(push_pc_o),
  .pop_pc_o(pop_pc_o), .load_vector_o(load_vector_o), .vector_o(vector_o),
  .restore_o(restore_o), .sleeping_o(sleeping_o), .wake_o(wake_o), .hresp_o(hresp_o));
`default_nettype wire

// [dv/ictl_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ictl_top_tb;
  logic               clk_i = 1'b0;
  logic               rst_b_i = 1'b0;
  logic [7:0]         haddr = 8'h00;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        hrdata;
  logic               hrdy, ext = 1'b0, t0 = 1'b0, rfi = 1'b0, slp = 1'b0, slow = 1'b0;
  logic [7:0]         eva = 8'h00, wca = 8'h00;
  logic               pca = 1'b0;
  logic               qen, idone, flush, push, pop, sleeping, wake;
  logic [3:0]         depth;
  ictl_pkg::ictl_ctx_s ctx = '{8'h3C, 8'hFF, 5'h11, 32'h0, 7'h22}, rctx;
  int                 n_errors = 0, checked = 0, c;
  logic [31:0]        r;
  always #20 clk_i = !clk_i;
  ictl_top i_ictl_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .ext_pin_i(ext), .timer0_ovf_i(t0),
    .pin_change_any_i(pca), .periph_evt_a_i(eva), .periph_evt_b_i(8'h00),
    .wake_capable_a_i(wca), .wake_capable_b_i(8'h00), .q_clk_en_i(qen),
    .instr_done_i(idone), .sleep_instr_i(slp), .return_from_irq_instr_i(rfi), .core_ctx_i(ctx),
    .flush_o(flush), .push_pc_o(push), .pop_pc_o(pop), .load_vector_o(), .vector_o(),
    .restore_o(), .restore_ctx_o(rctx), .sleeping_o(sleeping), .wake_o(wake));
  ictl_core_model i_ictl_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .push_pc_i(push), .pop_pc_i(pop), .q_clk_en_o(qen), .instr_done_o(idone),
    .depth_o(depth));
  task conclude;
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  // one clock, then bounded wait for ready
  task cyc;
    int k;
    @(posedge clk_i);
    for (k = 0; hrdy !== 1'b1; k++) begin
      if (k == 20) begin
        n_errors++;
        conclude;
      end
      @(posedge clk_i);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    cyc;
    htrans <= 2'h0;
    hwdata <= d;
    cyc;
    r = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task pulse_t0;
    t0 <= 1'b1;
    @(posedge clk_i);
    t0 <= 1'b0;
  endtask
  task ret;
    rfi <= 1'b1;
    @(posedge clk_i);
    rfi <= 1'b0;
  endtask
  // cycles until entry, n if none
  task wfl(input int n);
    for (c = 0; c < n && flush !== 1'b1; c++) @(posedge clk_i);
  endtask
  task s_regs;
    rd(ictl_pkg::A_CTRL, 32'h0);
    rd(8'h3C, 32'h0);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h7F);
    rd(ictl_pkg::A_CTRL, 32'h7E);
    pca <= 1'b1;
    @(posedge clk_i);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h20);
    rd(ictl_pkg::A_CTRL, 32'h21);
    pca <= 1'b0;
    @(posedge clk_i);
    rd(ictl_pkg::A_CTRL, 32'h20);
  endtask
  task s_entry;
    pulse_t0;
    wfl(16);
    chk(c, 16);
    rd(ictl_pkg::A_CTRL, 32'h24);
    bus(1'b1, ictl_pkg::A_CTRL, 32'hA4);
    wfl(16);
    chk(c < 16, 1);
    rd(ictl_pkg::A_CTRL, 32'h24);
    chk(depth, 1);
    rd(ictl_pkg::A_SH_W, 32'h3C);
    rd(ictl_pkg::A_SH_ST, 32'hE7);
    bus(1'b1, ictl_pkg::A_SH_W, 32'h5A);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h20);
    ret;
    @(posedge clk_i);
    chk(rctx.w, 8'h5A);
    rd(ictl_pkg::A_CTRL, 32'hA0);
    pulse_t0;
    wfl(16);
    chk(c < 16, 1);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h20);
    ret;
  endtask
  task s_group;
    bus(1'b1, ictl_pkg::A_PEN_A, 32'h01);
    eva <= 8'h01;
    @(posedge clk_i);
    eva <= 8'h00;
    wfl(16);
    chk(c, 16);
    rd(ictl_pkg::A_PFL_A, 32'h01);
    bus(1'b1, ictl_pkg::A_CTRL, 32'hC0);
    wfl(16);
    chk(c < 16, 1);
    bus(1'b1, ictl_pkg::A_PFL_A, 32'h0);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h0);
  endtask
  task s_ext;
    bus(1'b1, ictl_pkg::A_OPT, 32'h1);
    ext <= 1'b1;
    rd(ictl_pkg::A_CTRL, 32'h0);
    repeat (8) @(posedge clk_i);
    rd(ictl_pkg::A_CTRL, 32'h02);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h0);
    ext <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(ictl_pkg::A_CTRL, 32'h0);
    bus(1'b1, ictl_pkg::A_OPT, 32'h0);
    ext <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(ictl_pkg::A_CTRL, 32'h0);
    ext <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(ictl_pkg::A_CTRL, 32'h02);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h0);
  endtask
  task s_sleep;
    slow <= 1'b1;
    wca <= 8'h02;
    bus(1'b1, ictl_pkg::A_PFL_A, 32'h0);
    bus(1'b1, ictl_pkg::A_PEN_A, 32'h06);
    bus(1'b1, ictl_pkg::A_CTRL, 32'h40);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    @(posedge clk_i);
    chk(sleeping, 1);
    eva <= 8'h04;
    @(posedge clk_i);
    eva <= 8'h00;
    repeat (8) @(posedge clk_i);
    chk(sleeping, 1);
    eva <= 8'h02;
    @(posedge clk_i);
    eva <= 8'h00;
    for (c = 0; c < 40 && wake !== 1'b1; c++) @(posedge clk_i);
    chk(sleeping, 0);
    wfl(16);
    chk(c, 16);
    bus(1'b1, ictl_pkg::A_PFL_A, 32'h0);
    bus(1'b1, ictl_pkg::A_CTRL, 32'hC0);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    @(posedge clk_i);
    chk(sleeping, 1);
    eva <= 8'h02;
    @(posedge clk_i);
    eva <= 8'h00;
    for (c = 0; c < 40 && wake !== 1'b1; c++) @(posedge clk_i);
    chk(wake, 1);
    wfl(40);
    chk(c < 40, 1);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    s_regs;
    s_entry;
    s_group;
    s_ext;
    s_sleep;
    conclude;
  end
endmodule
`default_nettype wire
